/* pkg/gpc_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing counts of the game port
// Assumes: 8-bit register data, 4-bit register address, clk_sys at 100 MHz
// Notes:   Definitions only
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// Register offsets
`define GPC_OFF_CTL       4'h0
`define GPC_OFF_LST       4'h1
`define GPC_OFF_CNT_FIRST 4'h4
`define GPC_OFF_CNT_LAST  4'hb

// Port control register fields
`define GPC_CTL_MODE_BIT  0
`define GPC_CTL_EN_BIT    1
`define GPC_CTL_RESET     8'h02

// Legacy status layout: axes in the low nibble, buttons in the high nibble
`define GPC_LST_AXIS_LSB  0
`define GPC_LST_BTN_LSB   4

// Timing
`define GPC_CLK_MHZ       100
`define GPC_DISCH_NS      1500
`define GPC_DISCH_CYC     ((`GPC_DISCH_NS * `GPC_CLK_MHZ + 999) / 1000)
`define GPC_TICK_NS       1000
`define GPC_TICK_CYC      ((`GPC_TICK_NS * `GPC_CLK_MHZ) / 1000)

// Position counter full count
`define GPC_CNT_FULL      16'hffff

`endif

/* pkg/gpc_pkg.sv */
// Purpose: Types shared by the game port block
// Assumes: Offsets and counts live in gpc_regs.svh
// Notes:   Bus request travels as one packed struct
package gpc_pkg;

  // Per-axis measurement state
  typedef enum logic [1:0] {
    AX_HOLD,
    AX_CHARGE,
    AX_DISCH
  } gpc_axis_st_t;

  // Register bus request from software
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpc_bus_req_t;

endpackage

/* rtl/gpc_game_port.sv */
// Purpose: Game port front end for two analog game devices, axes and buttons
// Assumes: Axis lines are open drain with external RC charge networks
// Notes:   Axis order is device A X, A Y, device B X, B Y; buttons A0, A1, B0, B1
`timescale 1ns/1ps
`default_nettype none
`include "gpc_regs.svh"

// Operation
// - Idle enabled axis lines driven low.
// - Write to offset 1 releases axis lines.
// - Charge time observable per axis.
// - Sensed high starts about 1.5 us discharge.
// - After discharge hold low until restart.
// - Busy axis ignores new start writes.
// - Buttons reported raw in legacy status.
// - Two devices, two axes, two buttons.
// - Legacy polled and enhanced counted modes.
// - Control bit 0 selects mode, legacy default.
// - Axis status bit set while axis in charge state.
// - Enhanced mode uses four 16-bit counters.
module gpc_game_port #(
  parameter int NUM_AXES  = 4,
  parameter int NUM_BTNS  = 4,
  parameter int CNT_WIDTH = 16
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire gpc_pkg::gpc_bus_req_t busReq,
  output logic [7:0]                 busRdata,
  input  wire logic [NUM_AXES-1:0]   axisIn,
  output logic [NUM_AXES-1:0]        axisOut,
  output logic [NUM_AXES-1:0]        axisOe,
  input  wire logic [NUM_BTNS-1:0]   buttonIn,
  output logic                       portEnabled,
  output logic                       enhancedMode
);

  localparam logic [7:0]           DISCH_LAST = 8'(`GPC_DISCH_CYC - 1);
  localparam logic [7:0]           TICK_LAST  = 8'(`GPC_TICK_CYC - 1);
  localparam logic [CNT_WIDTH-1:0] CNT_FULL   = CNT_WIDTH'(`GPC_CNT_FULL);

  // Axis index addressed by a counter register offset
  function automatic logic [1:0] axisOf(input logic [3:0] addr);
    logic [3:0] idx;
    idx    = addr - `GPC_OFF_CNT_FIRST;
    axisOf = idx[2:1];
  endfunction

  // True when the offset falls on a position counter byte
  function automatic logic isCnt(input logic [3:0] addr);
    isCnt = (addr >= `GPC_OFF_CNT_FIRST) && (addr <= `GPC_OFF_CNT_LAST);
  endfunction

  // Synchroniser state
  logic [NUM_AXES-1:0] axisS1_q;
  logic [NUM_AXES-1:0] axisS2_q;
  logic [NUM_BTNS-1:0] btnS1_q;
  logic [NUM_BTNS-1:0] btnS2_q;

  // Control and bus state
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Counter tick prescaler
  logic [7:0] tick_q;
  logic [7:0] tick_d;
  logic       tickPulse;

  // Per-axis measurement state
  gpc_pkg::gpc_axis_st_t axSt_q   [NUM_AXES];
  gpc_pkg::gpc_axis_st_t axSt_d   [NUM_AXES];
  logic [7:0]            disch_q  [NUM_AXES];
  logic [7:0]            disch_d  [NUM_AXES];
  logic [CNT_WIDTH-1:0]  cnt_q    [NUM_AXES];
  logic [CNT_WIDTH-1:0]  cnt_d    [NUM_AXES];
  logic [7:0]            hiSnap_q [NUM_AXES];
  logic [7:0]            hiSnap_d [NUM_AXES];

  logic                startWr;
  logic [NUM_AXES-1:0] charging;

  // Two flops per input; only the second stage is used beyond this block
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      axisS1_q <= '0;
      axisS2_q <= '0;
      btnS1_q  <= '0;
      btnS2_q  <= '0;
    end
    else
    begin
      axisS1_q <= axisIn;
      axisS2_q <= axisS1_q;
      btnS1_q  <= buttonIn;
      btnS2_q  <= btnS1_q;
    end
  end

  // Mode and enable seen by the outside
  assign portEnabled  = ctl_q[`GPC_CTL_EN_BIT];
  assign enhancedMode = ctl_q[`GPC_CTL_MODE_BIT];

  // A write to the legacy status offset is the start command
  assign startWr = busReq.wr && (busReq.addr == `GPC_OFF_LST);

  // Prescaler for the 1 MHz position counting rate
  assign tickPulse = (tick_q == TICK_LAST);

  always_comb
  begin
    tick_d = tickPulse ? 8'h00 : tick_q + 8'h01;
  end

  // Per-axis measurement: hold low, charge, discharge
  always_comb
  begin
    for (int i = 0; i < NUM_AXES; i++)
    begin
      axSt_d[i]   = axSt_q[i];
      disch_d[i]  = disch_q[i];
      cnt_d[i]    = cnt_q[i];
      charging[i] = (axSt_q[i] == gpc_pkg::AX_CHARGE);
      case (axSt_q[i])
        gpc_pkg::AX_HOLD:
        begin
          if (startWr && portEnabled)
          begin
            axSt_d[i] = gpc_pkg::AX_CHARGE;
            cnt_d[i]  = '0;
          end
        end
        gpc_pkg::AX_CHARGE:
        begin
          if (axisS2_q[i])
          begin
            axSt_d[i]  = gpc_pkg::AX_DISCH;
            disch_d[i] = 8'h00;
          end
          else if (enhancedMode && tickPulse && (cnt_q[i] != CNT_FULL))
          begin
            cnt_d[i] = cnt_q[i] + 1'b1;
          end
        end
        gpc_pkg::AX_DISCH:
        begin
          disch_d[i] = disch_q[i] + 8'h01;
          if (disch_q[i] == DISCH_LAST)
          begin
            axSt_d[i] = gpc_pkg::AX_HOLD;
          end
        end
        default:
        begin
          axSt_d[i] = gpc_pkg::AX_HOLD;
        end
      endcase
    end
  end

  // Axis line drivers: low unless charging or port disabled
  always_comb
  begin
    axisOut = '0;
    for (int i = 0; i < NUM_AXES; i++)
    begin
      axisOe[i] = portEnabled && !charging[i];
    end
  end

  // Register writes, reads and high byte snapshot on low byte read
  always_comb
  begin
    ctl_d   = ctl_q;
    rdata_d = 8'h00;
    for (int i = 0; i < NUM_AXES; i++)
    begin
      hiSnap_d[i] = hiSnap_q[i];
    end
    if (busReq.wr && (busReq.addr == `GPC_OFF_CTL))
    begin
      ctl_d = {6'h00, busReq.wdata[`GPC_CTL_EN_BIT], busReq.wdata[`GPC_CTL_MODE_BIT]};
    end
    if (busReq.rd)
    begin
      if (busReq.addr == `GPC_OFF_CTL)
      begin
        rdata_d = ctl_q;
      end
      else if (busReq.addr == `GPC_OFF_LST)
      begin
        rdata_d[`GPC_LST_AXIS_LSB +: 4] = charging;
        rdata_d[`GPC_LST_BTN_LSB +: 4]  = btnS2_q;
      end
      else if (isCnt(busReq.addr))
      begin
        if (!busReq.addr[0])
        begin
          rdata_d = cnt_q[axisOf(busReq.addr)][7:0];
          hiSnap_d[axisOf(busReq.addr)] = cnt_q[axisOf(busReq.addr)][15:8];
        end
        else
        begin
          rdata_d = hiSnap_q[axisOf(busReq.addr)];
        end
      end
    end
  end

  assign busRdata = rdata_q;

  // State registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctl_q   <= `GPC_CTL_RESET;
      rdata_q <= 8'h00;
      tick_q  <= 8'h00;
      for (int i = 0; i < NUM_AXES; i++)
      begin
        axSt_q[i]   <= gpc_pkg::AX_HOLD;
        disch_q[i]  <= 8'h00;
        cnt_q[i]    <= '0;
        hiSnap_q[i] <= 8'h00;
      end
    end
    else
    begin
      ctl_q   <= ctl_d;
      rdata_q <= rdata_d;
      tick_q  <= tick_d;
      for (int i = 0; i < NUM_AXES; i++)
      begin
        axSt_q[i]   <= axSt_d[i];
        disch_q[i]  <= disch_d[i];
        cnt_q[i]    <= cnt_d[i];
        hiSnap_q[i] <= hiSnap_d[i];
      end
    end
  end

endmodule
`default_nettype wire

/* verif/gpc_joy_model.sv */
// Purpose: Game device with RC axis lines
// Assumes: Axis i charges in 20+100*i cycles, so axis spacing is whole counter ticks
// Notes:   Line reads low while driven
`timescale 1ns/1ps
`default_nettype none
module gpc_joy_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] axisOe,
  output var logic [3:0]  axisIn
);
  logic [9:0] cnt [4];
  // Charge time runs from release
  always_ff @(posedge clk_sys)
    for (int i = 0; i < 4; i++)
      cnt[i] <= axisOe[i] ? 10'h000 : cnt[i] + 10'(cnt[i] != 10'h3ff);
  // High once charged, low while driven
  always_comb
    for (int i = 0; i < 4; i++)
      axisIn[i] = !axisOe[i] && cnt[i] >= 10'(20 + 100 * i);
endmodule
`default_nettype wire

/* verif/gpc_game_port_asserts.sv */
// Purpose: Port checks of the game port
// Assumes: Axis 0 stands for all axes
// Notes:   Bound to every instance
`timescale 1ns/1ps
`default_nettype none
module gpc_game_port_asserts #(
  parameter int NUM_AXES  = 4,
  parameter int NUM_BTNS  = 4,
  parameter int CNT_WIDTH = 16
) (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire gpc_pkg::gpc_bus_req_t busReq,
  input wire logic [7:0]            busRdata,
  input wire logic [NUM_AXES-1:0]   axisIn,
  input wire logic [NUM_AXES-1:0]   axisOut,
  input wire logic [NUM_AXES-1:0]   axisOe,
  input wire logic [NUM_BTNS-1:0]   buttonIn,
  input wire logic                  portEnabled,
  input wire logic                  enhancedMode
);
  logic st;
  logic rs;
  // Start write and status read
  assign st = busReq.wr && busReq.addr == 4'h1;
  assign rs = busReq.rd && busReq.addr == 4'h1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_HOLD: assert property (axisOe[0] && !busReq.wr |=> axisOe[0])
    else $error("hold");
  AST_REL: assert property ($fell(axisOe[0]) && portEnabled |-> $past(st))
    else $error("release");
  AST_SENSE: assert property ($rose(axisOe[0]) && $past(portEnabled)
    |-> $past(axisIn[0], 3) && !$past(axisIn[0], 4)) else $error("sense");
  AST_DIS: assert property ($rose(axisOe[0]) && $past(portEnabled) |-> axisOe[0] [*8])
    else $error("discharge");
  AST_CHG: assert property (st && !axisOe[0] && !axisIn[0] && !$past(axisIn[0])
    |=> !axisOe[0]) else $error("charge");
  AST_AXB: assert property ($past(rs && portEnabled)
    |-> busRdata[3:0] == ~$past(axisOe)) else $error("axis bit");
  AST_BTN: assert property ($past(rs) && $past(buttonIn, 4) == buttonIn
    |-> busRdata[7:4] == buttonIn) else $error("button");
  AST_MODE: assert property ($past(busReq.wr && busReq.addr == 4'h0)
    |-> {portEnabled, enhancedMode} == $past(busReq.wdata[1:0])) else $error("mode");
  // Main scenarios
  cover property ($rose(axisOe[0]));
  cover property (st && axisOe[0]);
  cover property ($past(rs));
endmodule
bind gpc_game_port gpc_game_port_asserts #(.NUM_AXES(NUM_AXES), .NUM_BTNS(NUM_BTNS),
  .CNT_WIDTH(CNT_WIDTH)) chk (.clk_sys(clk_sys), .rst(rst), .busReq(busReq),
  .busRdata(busRdata), .axisIn(axisIn), .axisOut(axisOut), .axisOe(axisOe),
  .buttonIn(buttonIn), .portEnabled(portEnabled), .enhancedMode(enhancedMode));
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Bench for the game port
// Assumes: Model axis i charges in 20+100*i cycles
// Notes:   Reset, reading and mode tests
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  gpc_pkg::gpc_bus_req_t busReq = '0;
  logic [7:0]            busRdata;
  logic [3:0]            axisIn;
  logic [3:0]            axisOe;
  logic [3:0]            buttonIn = 4'ha;
  logic                  portEnabled;
  logic                  enhancedMode;
  int                    miscompares = 0;
  int                    num_checks = 0;
  int                    tUp [4];
  logic [7:0]            lo0;
  logic [7:0]            lo3;
  logic [7:0]            hi3;
  // Clock
  always #5 clk_sys = ~clk_sys;
  // Block and game device
  gpc_game_port uut (.clk_sys(clk_sys), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .axisIn(axisIn), .axisOut(), .axisOe(axisOe), .buttonIn(buttonIn),
    .portEnabled(portEnabled), .enhancedMode(enhancedMode));
  gpc_joy_model joy (.clk_sys(clk_sys), .axisOe(axisOe), .axisIn(axisIn));
  // Compare and count
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL %0t %h %h", $time, s, e);
    end
  endtask
  // One strobe cycle, write or read
  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys);
    busReq <= '{a, d, w, !w};
    @(posedge clk_sys);
    busReq <= '0;
    #1;
  endtask
  // Read and compare
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus(a, 8'h00, 1'b0);
    chk(busRdata, e);
  endtask
  // Read and hand back the data
  task automatic rdv(input logic [3:0] a, output logic [7:0] d);
    bus(a, 8'h00, 1'b0);
    d = busRdata;
  endtask
  // Wait until every axis is held low again, noting when each got there
  task automatic wait_held;
    for (int i = 0; i < 4; i++)
      tUp[i] = 0;
    for (int n = 0; n < 1000 && axisOe !== 4'hf; n++)
    begin
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < 4; i++)
        if (axisOe[i] && tUp[i] == 0)
          tUp[i] = n;
    end
    if (axisOe !== 4'hf)
    begin
      miscompares++;
      test_done();
    end
  endtask
  // Verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Test sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    chk({4'h0, axisOe}, 8'h0f);
    rdc(4'h0, 8'h02);
    rdc(4'h1, 8'ha0);
    bus(4'hd, 8'hff, 1'b1);
    rdc(4'hd, 8'h00);
    $display("reset test done");
    bus(4'h1, 8'h00, 1'b1);
    chk({4'h0, axisOe}, 8'h00);
    rdc(4'h1, 8'haf);
    bus(4'h1, 8'h00, 1'b1);
    wait_held();
    chk(8'(tUp[1] - tUp[0]), 8'h64);
    chk(8'(tUp[3] - tUp[2]), 8'h64);
    // Axes 0 and 1 are idle again, axes 2 and 3 still discharging
    bus(4'h1, 8'h00, 1'b1);
    chk({4'h0, axisOe}, 8'h0c);
    @(posedge clk_sys);
    buttonIn <= 4'h5;
    repeat (300) @(posedge clk_sys);
    rdc(4'h1, 8'h50);
    $display("reading test done");
    bus(4'h0, 8'h03, 1'b1);
    chk({6'h00, portEnabled, enhancedMode}, 8'h03);
    // Counters share one tick, so 300 cycles apart means exactly 3 ticks
    bus(4'h1, 8'h00, 1'b1);
    wait_held();
    rdv(4'h4, lo0);
    rdv(4'ha, lo3);
    rdv(4'hb, hi3);
    chk(lo3 - lo0, 8'h03);
    chk(hi3, 8'h00);
    repeat (160) @(posedge clk_sys);
    bus(4'h0, 8'h00, 1'b1);
    chk({4'h0, axisOe}, 8'h00);
    bus(4'h0, 8'h02, 1'b1);
    rdc(4'h0, 8'h02);
    bus(4'h1, 8'h00, 1'b1);
    chk({4'h0, axisOe}, 8'h00);
    $display("mode test done");
    test_done();
  end
endmodule
`default_nettype wire
